/* File: fcd_pkg.sv */
// Purpose: Shared constants and types for firmware commit and image download
// Assumes: 32-bit register port, one clock
// Notes:   Opcode values and register layout are local choices
`default_nettype none
package fcd_pkg;
	localparam logic [7:0] OPC_COMMIT   = 8'h10;
	localparam logic [7:0] OPC_DOWNLOAD = 8'h11;

	localparam logic [2:0] SCT_GENERIC = 3'h0;
	localparam logic [2:0] SCT_CMD     = 3'h1;
	localparam logic [7:0] SC_OK          = 8'h00;
	localparam logic [7:0] SC_BAD_OPCODE  = 8'h01;
	localparam logic [7:0] SC_BAD_FIELD   = 8'h02;
	localparam logic [7:0] SC_INTERNAL    = 8'h06;
	localparam logic [7:0] SC_BAD_SLOT    = 8'h06;
	localparam logic [7:0] SC_BAD_IMAGE   = 8'h07;
	localparam logic [7:0] SC_NEED_CONV   = 8'h0B;
	localparam logic [7:0] SC_NEED_SUBSYS = 8'h10;
	localparam logic [7:0] SC_NEED_RESET  = 8'h11;
	localparam logic [7:0] SC_MAX_TIME    = 8'h12;
	localparam logic [7:0] SC_PROHIBIT    = 8'h13;
	localparam logic [7:0] SC_OVERLAP     = 8'h14;

	localparam int ACT_LSB  = 3;
	localparam int ACT_MSB  = 5;
	localparam int SLOT_MSB = 2;

	localparam int          RNG_DEPTH  = 8;
	localparam logic [3:0]  RNG_FULL   = 4'h8;
	localparam logic [63:0] DW_BYTES   = 64'h0000_0000_0000_0004;
	localparam int          DW_SHIFT   = 2;
	localparam logic [2:0]  SLOT_RESET = 3'h1;

	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_MAXACT = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [2:0] CTRL_SLOTS_RESET = 3'h7;
	localparam logic [7:0] CTRL_RO_RESET    = 8'h00;
	localparam logic [15:0] MAXACT_RESET    = 16'h0064;

	typedef enum logic [2:0] {
		CA_REPLACE     = 3'b000,
		CA_REPLACE_ACT = 3'b001,
		CA_ACT_RESET   = 3'b010,
		CA_ACT_NOW     = 3'b011
	} fcd_action_type;

	typedef enum logic [1:0] {
		PEND_NONE   = 2'b00,
		PEND_ANY    = 2'b01,
		PEND_CONV   = 2'b10,
		PEND_SUBSYS = 2'b11
	} fcd_pend_type;

	typedef enum logic [1:0] {
		RST_CTRL   = 2'b00,
		RST_CONV   = 2'b01,
		RST_SUBSYS = 2'b10
	} fcd_rst_type;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_FETCH = 3'b001,
		ST_CHECK = 3'b010,
		ST_STORE = 3'b011
	} fcd_state_type;

	typedef struct packed {
		logic [7:0]  opcode;
		logic [63:0] prp1;
		logic [63:0] prp2;
		logic [31:0] cdw10;
		logic [31:0] cdw11;
	} fcd_cmd_type;

	typedef struct packed {
		logic [2:0] sct;
		logic [7:0] sc;
	} fcd_cpl_type;

	typedef struct packed {
		logic         done;
		logic         fail;
		logic         img_ok;
		logic         prohibited;
		fcd_pend_type needs;
		logic [15:0]  act_time;
	} fcd_store_type;
endpackage
`default_nettype wire

/* File: fcd_core.sv */
// Purpose: Firmware commit and image download command handling
// Assumes: Commands arrive one at a time; slot store answers each request
// Notes:   Download data is fetched one dword per beat from host memory
// Overview of operation
// - Commit posts a completion once the requested action is finished.
// - Commit pending with success activates the named image at next reset.
// - Storage write failure completes commit with generic Internal Error.
// - Slot read-only, invalid or above supported count returns 06h.
// - Invalid image for activation returns 07h and is not loaded.
// - 0Bh: needs conventional reset; controller or FLR reset keeps old image.
// - 10h: needs subsystem reset; any other reset keeps old image.
// - 11h: image needs a reset and is activated at the next reset.
// - 12h when immediate activation exceeds max activation time; host reissues.
// - 13h when the image is refused for vendor reasons.
// - 14h when downloaded pieces cover overlapping dword ranges.
// - Download accepted while other commands remain outstanding; this core takes a command only in ST_IDLE.
// - Image built from pieces, each with dword offset and count.
// - Pieces accepted in any order, each placed by its offset.
// - Download never activates an image; it only copies data.
// - Download uses only both PRP entries and dwords 10 and 11.
// - First PRP entry gives the host address of the piece data.
// - Dword 10 holds a zero-based dword count.
// - Dword 11 holds the dword offset from the image start.
// - Each download posts a completion once its piece is received.
// - Commit action: 000 replace, 001 replace+reset, 010 reset, 011 now.
`timescale 1ns/1ps
`default_nettype none
module fcd_core (
	input  wire logic                  sys_clk,
	input  wire logic                  arst_n,
	input  wire fcd_pkg::fcd_cmd_type  cmd,
	input  wire logic                  cmd_valid,
	output logic                       cmd_ready,
	output var  fcd_pkg::fcd_cpl_type  cpl,
	output logic                       cpl_valid,
	output logic                       fetch_req,
	output logic [63:0]                fetch_addr,
	output logic [63:0]                fetch_prp2,
	input  wire logic                  fetch_vld,
	input  wire logic [31:0]           fetch_data,
	output logic                       stage_we,
	output logic [31:0]                stage_addr,
	output logic [31:0]                stage_data,
	output logic                       store_req,
	output logic                       store_replace,
	output logic [2:0]                 store_slot,
	input  wire fcd_pkg::fcd_store_type store_info,
	input  wire logic                  rst_evt,
	input  wire fcd_pkg::fcd_rst_type  rst_kind,
	output logic                       act_pulse,
	output logic [2:0]                 act_slot,
	input  wire logic [7:0]            reg_addr,
	input  wire logic [31:0]           reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic [31:0]                reg_rdata
);
	fcd_pkg::fcd_state_type  state;
	fcd_pkg::fcd_state_type  next_state;
	fcd_pkg::fcd_pend_type   pend;
	fcd_pkg::fcd_pend_type   ev_pend;
	fcd_pkg::fcd_cpl_type    next_cpl;
	fcd_pkg::fcd_cpl_type    ev_cpl;
	logic [31:0]             dl_count;
	logic [31:0]             dl_ofs;
	logic [31:0]             idx;
	logic [2:0]              cm_action;
	logic [2:0]              cm_slot;
	logic [2:0]              pend_slot;
	logic [2:0]              slots_supported;
	logic [7:0]              ro_mask;
	logic [15:0]             max_activation_time;
	logic                    overlap;
	logic [3:0]              rng_cnt;
	logic [31:0]             rng_start [fcd_pkg::RNG_DEPTH];
	logic [31:0]             rng_end [fcd_pkg::RNG_DEPTH];
	logic                    rng_used [fcd_pkg::RNG_DEPTH];
	logic [fcd_pkg::RNG_DEPTH-1:0] hit;
	logic                    ev_now;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	// Command acceptance and decode
	wire take    = cmd_valid && cmd_ready;
	wire take_dl = take && cmd.opcode == fcd_pkg::OPC_DOWNLOAD;
	wire take_cm = take && cmd.opcode == fcd_pkg::OPC_COMMIT;
	wire take_bad = take && !take_dl && !take_cm;
	wire beat    = state == fcd_pkg::ST_FETCH && fetch_vld;
	wire last_beat = beat && idx == dl_count;
	wire [31:0] new_end = 32'(cmd.cdw11 + cmd.cdw10);

	wire [2:0] slot_sel = cm_slot == 3'h0 ? act_slot : cm_slot;
	wire is_replace = cm_action == fcd_pkg::CA_REPLACE
		|| cm_action == fcd_pkg::CA_REPLACE_ACT;
	wire act_legal = cm_action[2] == 1'b0;
	wire slot_bad = slot_sel > slots_supported
		|| (is_replace && ro_mask[slot_sel]);
	wire check_err = !act_legal || slot_bad || (is_replace && overlap);
	wire cm_done = state == fcd_pkg::ST_STORE && store_info.done;
	wire rng_clear = cm_done && is_replace;
	wire rng_rec = take_dl && rng_cnt != fcd_pkg::RNG_FULL;
	wire over_set = take_dl && |hit;

	wire cpl_now = take_bad || last_beat || cm_done
		|| (state == fcd_pkg::ST_CHECK && check_err);

	// Completion selection
	always_comb begin
		next_cpl = '{sct: fcd_pkg::SCT_GENERIC, sc: fcd_pkg::SC_OK};
		if (take_bad) begin
			next_cpl.sc = fcd_pkg::SC_BAD_OPCODE;
		end else if (state == fcd_pkg::ST_CHECK) begin
			if (!act_legal) begin
				next_cpl.sc = fcd_pkg::SC_BAD_FIELD;
			end else if (slot_bad) begin
				next_cpl = '{sct: fcd_pkg::SCT_CMD, sc: fcd_pkg::SC_BAD_SLOT};
			end else begin
				next_cpl = '{sct: fcd_pkg::SCT_CMD, sc: fcd_pkg::SC_OVERLAP};
			end
		end else if (state == fcd_pkg::ST_STORE) begin
			next_cpl = ev_cpl;
		end
	end

	// Outcome of a commit once the slot store has answered
	always_comb begin
		ev_cpl = '{sct: fcd_pkg::SCT_CMD, sc: fcd_pkg::SC_OK};
		ev_pend = fcd_pkg::PEND_NONE;
		ev_now = 1'b0;
		if (store_info.fail) begin
			ev_cpl = '{sct: fcd_pkg::SCT_GENERIC, sc: fcd_pkg::SC_INTERNAL};
		end else if (cm_action == fcd_pkg::CA_REPLACE) begin
			ev_cpl.sc = fcd_pkg::SC_OK;
		end else if (!store_info.img_ok) begin
			ev_cpl.sc = fcd_pkg::SC_BAD_IMAGE;
		end else if (store_info.prohibited) begin
			ev_cpl.sc = fcd_pkg::SC_PROHIBIT;
		end else if (cm_action != fcd_pkg::CA_ACT_NOW) begin
			ev_pend = fcd_pkg::PEND_ANY;
		end else if (store_info.act_time > max_activation_time) begin
			ev_cpl.sc = fcd_pkg::SC_MAX_TIME;
		end else begin
			unique case (store_info.needs)
				fcd_pkg::PEND_NONE: ev_now = 1'b1;
				fcd_pkg::PEND_ANY: begin
					ev_cpl.sc = fcd_pkg::SC_NEED_RESET;
					ev_pend = fcd_pkg::PEND_ANY;
				end
				fcd_pkg::PEND_CONV: begin
					ev_cpl.sc = fcd_pkg::SC_NEED_CONV;
					ev_pend = fcd_pkg::PEND_CONV;
				end
				fcd_pkg::PEND_SUBSYS: begin
					ev_cpl.sc = fcd_pkg::SC_NEED_SUBSYS;
					ev_pend = fcd_pkg::PEND_SUBSYS;
				end
			endcase
		end
		// Success carries the generic status type
		if (ev_cpl.sc == fcd_pkg::SC_OK) begin
			ev_cpl.sct = fcd_pkg::SCT_GENERIC;
		end
	end

	always_comb begin
		next_state = state;
		unique case (state)
			fcd_pkg::ST_IDLE: begin
				if (take_dl) begin
					next_state = fcd_pkg::ST_FETCH;
				end else if (take_cm) begin
					next_state = fcd_pkg::ST_CHECK;
				end
			end
			fcd_pkg::ST_FETCH: begin
				if (last_beat) begin
					next_state = fcd_pkg::ST_IDLE;
				end
			end
			fcd_pkg::ST_CHECK: begin
				next_state = check_err ? fcd_pkg::ST_IDLE : fcd_pkg::ST_STORE;
			end
			fcd_pkg::ST_STORE: begin
				if (store_info.done) begin
					next_state = fcd_pkg::ST_IDLE;
				end
			end
			default: next_state = fcd_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= fcd_pkg::ST_IDLE;
			cmd_ready <= 1'b0;
			cpl_valid <= 1'b0;
			cpl <= '0;
		end else begin
			state <= next_state;
			cmd_ready <= next_state == fcd_pkg::ST_IDLE;
			cpl_valid <= cpl_now;
			cpl <= cpl_now ? next_cpl : '0;
		end
	end

	// Download: latch piece, fetch from PRP1, write staging store
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			dl_count <= '0;
			dl_ofs <= '0;
			idx <= '0;
			fetch_addr <= '0;
			fetch_prp2 <= '0;
		end else if (take_dl) begin
			dl_count <= cmd.cdw10;
			dl_ofs <= cmd.cdw11;
			idx <= '0;
			fetch_addr <= cmd.prp1;
			fetch_prp2 <= cmd.prp2;
		end else if (beat) begin
			idx <= 32'(idx + 32'h0000_0001);
			fetch_addr <= 64'(fetch_addr + fcd_pkg::DW_BYTES);
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fetch_req <= 1'b0;
			stage_we <= 1'b0;
			stage_addr <= '0;
			stage_data <= '0;
		end else begin
			fetch_req <= next_state == fcd_pkg::ST_FETCH;
			stage_we <= beat;
			stage_addr <= 32'((dl_ofs + idx) << fcd_pkg::DW_SHIFT);
			stage_data <= fetch_data;
		end
	end

	// Commit: latch fields, ask the slot store
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cm_action <= fcd_pkg::CA_REPLACE;
			cm_slot <= '0;
			store_req <= 1'b0;
			store_replace <= 1'b0;
			store_slot <= '0;
		end else begin
			if (take_cm) begin
				cm_action <= cmd.cdw10[fcd_pkg::ACT_MSB:fcd_pkg::ACT_LSB];
				cm_slot <= cmd.cdw10[fcd_pkg::SLOT_MSB:0];
			end
			store_req <= state == fcd_pkg::ST_CHECK && !check_err;
			store_replace <= is_replace;
			store_slot <= slot_sel;
		end
	end

	// Activation bookkeeping; downloads never reach here
	wire fire = rst_evt && (pend == fcd_pkg::PEND_ANY
		|| (pend == fcd_pkg::PEND_CONV && rst_kind != fcd_pkg::RST_CTRL)
		|| (pend == fcd_pkg::PEND_SUBSYS && rst_kind == fcd_pkg::RST_SUBSYS));

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pend <= fcd_pkg::PEND_NONE;
			pend_slot <= '0;
			act_pulse <= 1'b0;
			act_slot <= fcd_pkg::SLOT_RESET;
		end else begin
			act_pulse <= fire || (cm_done && ev_now);
			if (fire) begin
				act_slot <= pend_slot;
				pend <= fcd_pkg::PEND_NONE;
			end
			if (cm_done && ev_now) begin
				act_slot <= slot_sel;
			end else if (cm_done && ev_pend != fcd_pkg::PEND_NONE) begin
				pend <= ev_pend;
				pend_slot <= slot_sel;
			end
		end
	end

	// Range table of received pieces
	for (genvar g = 0; g < fcd_pkg::RNG_DEPTH; g++) begin : g_rng
		assign hit[g] = rng_used[g] && cmd.cdw11 <= rng_end[g]
			&& rng_start[g] <= new_end;
		always_ff @(posedge sys_clk or negedge arst_n) begin
			if (!arst_n) begin
				rng_used[g] <= 1'b0;
				rng_start[g] <= '0;
				rng_end[g] <= '0;
			end else if (rng_clear) begin
				rng_used[g] <= 1'b0;
			end else if (rng_rec && rng_cnt == 4'(g)) begin
				rng_used[g] <= 1'b1;
				rng_start[g] <= cmd.cdw11;
				rng_end[g] <= new_end;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rng_cnt <= '0;
			overlap <= 1'b0;
		end else begin
			if (rng_clear) begin
				rng_cnt <= '0;
			end else if (rng_rec) begin
				rng_cnt <= 4'(rng_cnt + 4'h1);
			end
			if (over_set) begin
				overlap <= 1'b1;
			end else if (rng_clear) begin
				overlap <= 1'b0;
			end
		end
	end

	// Register port
	wire wr_ctrl = reg_wr && reg_addr == fcd_pkg::REG_CTRL;
	wire wr_max = reg_wr && reg_addr == fcd_pkg::REG_MAXACT;
	wire [31:0] rd_mux =
		reg_addr == fcd_pkg::REG_CTRL ? {16'h0000, ro_mask, 5'h00, slots_supported} :
		reg_addr == fcd_pkg::REG_MAXACT ? {16'h0000, max_activation_time} :
		reg_addr == fcd_pkg::REG_STATUS ? {19'h0_0000, rng_cnt, overlap,
			pend, pend_slot, act_slot} : 32'h0000_0000;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			slots_supported <= fcd_pkg::CTRL_SLOTS_RESET;
			ro_mask <= fcd_pkg::CTRL_RO_RESET;
			max_activation_time <= fcd_pkg::MAXACT_RESET;
			reg_rdata <= '0;
		end else begin
			if (wr_ctrl) begin
				slots_supported <= reg_wdata[2:0];
				ro_mask <= reg_wdata[15:8];
			end
			if (wr_max) begin
				max_activation_time <= reg_wdata[15:0];
			end
			reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
		end
	end

	sequence s_last_piece;
		last_beat;
	endsequence
	sequence s_cpl_ok;
		cpl_valid && cpl.sc == fcd_pkg::SC_OK;
	endsequence

	commit_cpl_a: assert property (cm_done |=> cpl_valid)
		else $error("commit completion missing");
	reset_act_a: assert property (rst_evt && pend == fcd_pkg::PEND_ANY
		|=> act_pulse && act_slot == $past(pend_slot))
		else $error("pending image not activated on reset");
	store_fail_a: assert property (cm_done && store_info.fail
		|=> cpl.sct == fcd_pkg::SCT_GENERIC
		&& cpl.sc == fcd_pkg::SC_INTERNAL)
		else $error("store failure not internal error");
	bad_slot_a: assert property (state == fcd_pkg::ST_CHECK && act_legal
		&& slot_bad |=> cpl_valid && cpl.sc == fcd_pkg::SC_BAD_SLOT
		&& !store_req)
		else $error("bad slot not reported");
	conv_keep_a: assert property (rst_evt && rst_kind == fcd_pkg::RST_CTRL
		&& pend == fcd_pkg::PEND_CONV && !cm_done
		|=> !act_pulse && pend == fcd_pkg::PEND_CONV)
		else $error("conventional-reset image activated early");
	subsys_keep_a: assert property (rst_evt && rst_kind != fcd_pkg::RST_SUBSYS
		&& pend == fcd_pkg::PEND_SUBSYS && !cm_done
		|=> !act_pulse)
		else $error("subsystem-reset image activated early");
	max_time_a: assert property (cm_done && !store_info.fail
		&& cm_action == fcd_pkg::CA_ACT_NOW && store_info.img_ok
		&& !store_info.prohibited
		&& store_info.act_time > max_activation_time
		|=> cpl.sc == fcd_pkg::SC_MAX_TIME && !act_pulse)
		else $error("max activation time not enforced");
	overlap_a: assert property (state == fcd_pkg::ST_CHECK && act_legal
		&& !slot_bad && is_replace && overlap
		|=> cpl.sc == fcd_pkg::SC_OVERLAP)
		else $error("overlap not reported");
	dl_no_act_a: assert property (state == fcd_pkg::ST_FETCH && !rst_evt
		|=> $stable(act_slot) && !act_pulse)
		else $error("download changed active image");
	stage_addr_a: assert property (beat |=> stage_we
		&& stage_addr == 32'(($past(dl_ofs) + $past(idx)) << 2))
		else $error("staging address wrong");
	dl_cpl_a: assert property (s_last_piece |=> s_cpl_ok
		##1 (!cpl_valid || $past(take_bad)))
		else $error("download completion missing");
endmodule
`default_nettype wire

/* File: fcd_far.sv */
// Purpose: Host memory and slot store model facing fcd_core
// Assumes: Host memory word at an address is that address xor a fixed mask
// Notes:   lat stretches both the fetch and the store answers
`timescale 1ns/1ps
`default_nettype none
module fcd_far (
	input  wire logic                   sys_clk,
	input  wire logic                   arst_n,
	input  wire logic                   fetch_req,
	input  wire logic [63:0]            fetch_addr,
	output logic                        fetch_vld,
	output logic [31:0]                 fetch_data,
	input  wire logic                   store_req,
	output var fcd_pkg::fcd_store_type  store_info,
	input  wire fcd_pkg::fcd_store_type store_set,
	input  wire logic [3:0]             lat
);
	logic        had;
	logic [63:0] last;
	logic [31:0] lastd;
	logic [3:0]  cnt;
	logic [3:0]  scnt;
	logic        sbusy;
	logic        done;

	// Each address is served once; a new address starts a new beat
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fetch_vld <= 1'b0;
			had       <= 1'b0;
			last      <= 64'h0000_0000_0000_0000;
			lastd     <= 32'h0000_0000;
			cnt       <= 4'h0;
		end else begin
			fetch_vld <= 1'b0;
			if (!fetch_req) begin
				had <= 1'b0;
				cnt <= 4'h0;
			end else if (!fetch_vld && (!had || fetch_addr != last)) begin
				if (cnt == lat) begin
					fetch_vld <= 1'b1;
					lastd     <= fetch_addr[31:0] ^ 32'hC3C3_0000;
					last      <= fetch_addr;
					had       <= 1'b1;
					cnt       <= 4'h0;
				end else begin
					cnt <= cnt + 4'h1;
				end
			end
		end
	end
	// Released data line shows the inverse of the last word
	assign fetch_data = fetch_vld ? lastd : ~lastd;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sbusy <= 1'b0;
			scnt  <= 4'h0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (store_req) begin
				sbusy <= 1'b1;
				scnt  <= 4'h0;
			end else if (sbusy) begin
				if (scnt == lat) begin
					done  <= 1'b1;
					sbusy <= 1'b0;
				end else begin
					scnt <= scnt + 4'h1;
				end
			end
		end
	end
	assign store_info = done ?
		fcd_pkg::fcd_store_type'({1'b1, store_set[20:0]}) :
		fcd_pkg::fcd_store_type'(~{1'b1, store_set[20:0]});
endmodule
`default_nettype wire

/* File: firmware_commit_and_download_bench.sv */
// Purpose: Self-checking bench for fcd_core
// Assumes: fcd_far stands for host memory and the slot store
// Notes:   Outputs are read just after an edge, before its updates land
`timescale 1ns/1ps
`default_nettype none
module firmware_commit_and_download_bench;
	localparam logic [2:0] GEN = fcd_pkg::SCT_GENERIC;
	localparam logic [2:0] CSP = fcd_pkg::SCT_CMD;
	localparam logic [4:0] F_OK = 5'h08;
	localparam logic [4:0] F_FAIL = 5'h18;
	localparam logic [4:0] F_BAD = 5'h00;
	localparam logic [4:0] F_PRO = 5'h0C;
	logic                   sys_clk = 1'b0;
	logic                   arst_n = 1'b0;
	fcd_pkg::fcd_cmd_type   cmd;
	logic                   cmd_valid, cmd_ready, cpl_valid;
	fcd_pkg::fcd_cpl_type   cpl;
	logic                   fetch_req, fetch_vld, stage_we, store_req;
	logic                   store_replace, rst_evt, act_pulse;
	logic                   reg_wr, reg_rd;
	logic [63:0]            fetch_addr, fetch_prp2;
	logic [31:0]            fetch_data, stage_addr, stage_data;
	logic [31:0]            reg_wdata, reg_rdata;
	logic [2:0]             store_slot, act_slot;
	fcd_pkg::fcd_store_type store_info, store_set;
	fcd_pkg::fcd_rst_type   rst_kind;
	logic [7:0]             reg_addr;
	logic [3:0]             lat;
	logic [10:0]            got;
	logic [63:0]            stq[$];
	int                     bad_count = 0;
	int                     tests_run = 0;
	int                     act_n = 0;

	fcd_core DUT (.sys_clk(sys_clk), .arst_n(arst_n), .cmd(cmd),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cpl(cpl),
		.cpl_valid(cpl_valid), .fetch_req(fetch_req),
		.fetch_addr(fetch_addr), .fetch_prp2(fetch_prp2),
		.fetch_vld(fetch_vld), .fetch_data(fetch_data),
		.stage_we(stage_we), .stage_addr(stage_addr),
		.stage_data(stage_data), .store_req(store_req),
		.store_replace(store_replace), .store_slot(store_slot),
		.store_info(store_info), .rst_evt(rst_evt), .rst_kind(rst_kind),
		.act_pulse(act_pulse), .act_slot(act_slot), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));
	fcd_far far (.sys_clk(sys_clk), .arst_n(arst_n), .fetch_req(fetch_req),
		.fetch_addr(fetch_addr), .fetch_vld(fetch_vld),
		.fetch_data(fetch_data), .store_req(store_req),
		.store_info(store_info), .store_set(store_set), .lat(lat));

	always #5 sys_clk = ~sys_clk;
	always @(negedge sys_clk) begin
		if (stage_we === 1'b1)
			stq.push_back({stage_addr, stage_data});
		if (act_pulse === 1'b1)
			act_n++;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		if (bad_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk) begin
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
		end
		@(posedge sys_clk) reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk) begin
			reg_addr <= a;
			reg_rd <= 1'b1;
		end
		@(posedge sys_clk) reg_rd <= 1'b0;
		@(posedge sys_clk) chk(reg_rdata, e);
	endtask
	task automatic send(input logic [7:0] op, input logic [63:0] p1,
		input logic [31:0] c10, input logic [31:0] c11);
		int n;
		@(posedge sys_clk) begin
			cmd <= fcd_pkg::fcd_cmd_type'({op, p1, ~p1, c10, c11});
			cmd_valid <= 1'b1;
		end
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (cmd_ready !== 1'b1 && n < 100);
		cmd_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (cpl_valid !== 1'b1 && n < 100);
		if (n >= 100)
			bad_count++;
		got = cpl;
	endtask
	task automatic dl(input logic [31:0] ofs, input logic [31:0] m1,
		input logic [63:0] p1);
		int n0;
		logic [31:0] k;
		logic [63:0] e;
		n0 = act_n;
		send(fcd_pkg::OPC_DOWNLOAD, p1, m1, ofs);
		chk({21'h0, got}, 32'h0000_0000);
		chk({31'h0, fetch_req}, 32'h0000_0000);
		chk(fetch_prp2[31:0], ~p1[31:0]);
		chk(fetch_prp2[63:32], ~p1[63:32]);
		chk(32'(stq.size()), m1 + 32'h1);
		k = 32'h0;
		while (stq.size() > 0) begin
			e = stq.pop_front();
			chk(e[63:32], (ofs + k) * 32'h4);
			chk(e[31:0], (p1[31:0] + k * 32'h4) ^ 32'hC3C3_0000);
			k = k + 32'h1;
		end
		chk(32'(act_n), 32'(n0));
	endtask
	task automatic commit(input logic [2:0] a, input logic [2:0] s,
		input logic [4:0] f, input logic [15:0] t, input logic [10:0] e);
		store_set <= fcd_pkg::fcd_store_type'({1'b0, f, t});
		send(fcd_pkg::OPC_COMMIT, 64'h0, {26'h0, a, s}, 32'h0);
		chk({21'h0, got}, {21'h0, e});
		chk({28'h0, store_replace, store_slot}, {28'h0, a[2:1] == 2'b00, s});
	endtask
	task automatic revt(input fcd_pkg::fcd_rst_type k, input logic [2:0] e);
		@(posedge sys_clk) begin
			rst_evt <= 1'b1;
			rst_kind <= k;
		end
		@(posedge sys_clk) rst_evt <= 1'b0;
		@(posedge sys_clk);
		@(posedge sys_clk) chk({29'h0, act_slot}, {29'h0, e});
	endtask

	initial begin
		#(32'h0003_0D40);
		bad_count++;
		final_report;
	end
	initial begin
		cmd = '0;
		cmd_valid = 1'b0;
		store_set = '0;
		rst_evt = 1'b0;
		rst_kind = fcd_pkg::RST_CTRL;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		lat = 4'h0;
		repeat (12) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd(fcd_pkg::REG_CTRL, 32'h0000_0007);
		rd(fcd_pkg::REG_MAXACT, 32'h0000_0064);
		rd(fcd_pkg::REG_STATUS, 32'h0000_0001);
		rd(8'h0C, 32'h0000_0000);
		wr(fcd_pkg::REG_STATUS, 32'hFFFF_FFFF);
		rd(fcd_pkg::REG_STATUS, 32'h0000_0001);
		dl(32'h4, 32'h1, 64'h0000_0000_0000_1000);
		dl(32'h0, 32'h3, 64'h0000_0000_0000_2000);
		rd(fcd_pkg::REG_STATUS, 32'h0000_0401);
		commit(3'b000, 3'h2, F_OK, 16'h0, {GEN, fcd_pkg::SC_OK});
		rd(fcd_pkg::REG_STATUS, 32'h0000_0001);
		lat <= 4'h3;
		dl(32'h0, 32'h2, 64'h0000_0000_0000_3000);
		wr(fcd_pkg::REG_CTRL, 32'h0000_0403);
		rd(fcd_pkg::REG_CTRL, 32'h0000_0403);
		commit(3'b000, 3'h5, F_OK, 16'h0, {CSP, fcd_pkg::SC_BAD_SLOT});
		commit(3'b000, 3'h2, F_OK, 16'h0, {CSP, fcd_pkg::SC_BAD_SLOT});
		commit(3'b011, 3'h2, F_OK, 16'h0, {GEN, fcd_pkg::SC_OK});
		chk({29'h0, act_slot}, 32'h2);
		commit(3'b100, 3'h1, F_OK, 16'h0, {GEN, fcd_pkg::SC_BAD_FIELD});
		send(8'h7F, 64'h0, 32'h0, 32'h0);
		chk({21'h0, got}, {21'h0, GEN, fcd_pkg::SC_BAD_OPCODE});
		wr(fcd_pkg::REG_CTRL, 32'h0000_0007);
		commit(3'b011, 3'h3, F_FAIL, 16'h0, {GEN, fcd_pkg::SC_INTERNAL});
		commit(3'b011, 3'h3, F_BAD, 16'h0, {CSP, fcd_pkg::SC_BAD_IMAGE});
		chk({29'h0, act_slot}, 32'h2);
		commit(3'b011, 3'h3, F_PRO, 16'h0, {CSP, fcd_pkg::SC_PROHIBIT});
		commit(3'b011, 3'h3, F_OK, 16'h0065, {CSP, fcd_pkg::SC_MAX_TIME});
		commit(3'b001, 3'h3, F_OK, 16'h0065, {GEN, fcd_pkg::SC_OK});
		revt(fcd_pkg::RST_CTRL, 3'h3);
		wr(fcd_pkg::REG_MAXACT, 32'h0000_0065);
		commit(3'b011, 3'h1, F_OK, 16'h0065, {GEN, fcd_pkg::SC_OK});
		chk({29'h0, act_slot}, 32'h1);
		commit(3'b010, 3'h4, F_OK, 16'h0, {GEN, fcd_pkg::SC_OK});
		revt(fcd_pkg::RST_SUBSYS, 3'h4);
		commit(3'b011, 3'h2, 5'h0A, 16'h0, {CSP, fcd_pkg::SC_NEED_CONV});
		revt(fcd_pkg::RST_CTRL, 3'h4);
		revt(fcd_pkg::RST_CONV, 3'h2);
		commit(3'b011, 3'h3, 5'h0B, 16'h0, {CSP, fcd_pkg::SC_NEED_SUBSYS});
		revt(fcd_pkg::RST_CONV, 3'h2);
		revt(fcd_pkg::RST_SUBSYS, 3'h3);
		commit(3'b011, 3'h5, 5'h09, 16'h0, {CSP, fcd_pkg::SC_NEED_RESET});
		revt(fcd_pkg::RST_CTRL, 3'h5);
		// Overlapping pieces sent on purpose
		dl(32'h0, 32'h1, 64'h0000_0000_0000_4000);
		dl(32'h1, 32'h0, 64'h0000_0000_0000_5000);
		rd(fcd_pkg::REG_STATUS, 32'h0000_052D);
		commit(3'b000, 3'h2, F_OK, 16'h0, {CSP, fcd_pkg::SC_OVERLAP});
		arst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd(fcd_pkg::REG_STATUS, 32'h0000_0001);
		final_report;
	end
endmodule
`default_nettype wire
